/* rtl/asr_rx.v */
// Asynchronous serial receiver with register port
//
// Contract
// [R1] Character length is 8 or 9 data bits, chosen by a control bit.
// [R2] Ninth-bit status holds data bit 8, or bit 7 in 8-bit mode.
// [R3] Complete character moves to the data buffer and sets the full flag.
// [R4] Full flag with its enable raises the receiver interrupt.
// [R5] Line is sampled on a tick running at sixteen times the baud rate.
// [R6] Tick counter resyncs after start bit and after a one-to-zero bit change.
// [R7] Start search: a low sample after three highs starts the count.
// [R8] Start verified at ticks 3, 5, 7; two highs fail, one high is noise.
// [R9] Failed start verification resets the counter and resumes the search.
// [R10] Data bit is majority of ticks 8, 9, 10; disagreement flags noise.
// [R11] High samples at ticks 8-10 of start bit flag noise only.
// [R12] Stop bit majority low sets framing error; disagreement flags noise.
// [R13] Framing error posts with the full flag; breaks also set it.
// [R14] Counter resyncs on valid falling edges inside a character.
// [R15] Standby bit suppresses all receiver interrupt requests.
// [R16] Address-mark wake: character with msb one clears standby and sets full.
// [R17] Idle wake: idle character clears standby without setting the idle flag.
// [R18] Software compares the address and may set standby again.
// [R19] Idle flag after 10 or 11 high bits; its enable requests an interrupt.
// [R20] Idle origin bit picks counting after start bit or after stop bit.
// [R21] Character arriving while buffer full sets overrun, new one discarded.
// [R22] Wake select one is address mark, zero is idle; resets to zero.
// [R23] Data bits arrive lsb first between start and stop bits.
// [R24] Noise over the whole character posts together with the full flag.
//
// Design decisions made here: the address map and strobed register access.
`include "asr_defs.vh"
module asr_rx (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_serial_in_pin,
  input wire [2:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rd_data,
  output wire o_rx_irq
);
  localparam ST_HUNT = 1'b0;
  localparam ST_RECV = 1'b1;

  reg [7:0] ctrl_one_r;
  reg [7:0] baud_div_r;
  reg full_irq_en_r;
  reg quiet_irq_en_r;
  reg standby_r;
  reg ninth_r;
  reg [7:0] data_buf_r;
  reg full_r;
  reg quiet_r;
  reg overrun_r;
  reg noise_r;
  reg framing_r;

  reg st_r;
  reg [3:0] rt_r;
  reg [3:0] bit_r;
  reg [2:0] hist_r;
  reg [4:0] smp_r;
  reg last_smp_r;
  reg prev_one_r;
  reg [8:0] shf_r;
  reg nacc_r;
  reg fe_r;
  reg done_r;
  reg [3:0] quiet_bits_r;
  reg [3:0] quiet_sub_r;
  reg quiet_arm_r;
  reg quiet_hit_r;

  wire tick;
  wire rx_en = ctrl_one_r[`ASR_C1_RX_EN];
  wire nine = ctrl_one_r[`ASR_C1_CHAR_LEN];
  wire wake_addr = ctrl_one_r[`ASR_C1_WAKE_SEL];
  wire origin_stop = ctrl_one_r[`ASR_C1_QUIET_ORIGIN];
  wire smp = i_serial_in_pin;
  wire [2:0] win = {smp_r[1:0], smp};
  wire vote = (win[0] & win[1]) | (win[0] & win[2]) | (win[1] & win[2]);
  wire split = (win != 3'b000) && (win != 3'b111);
  wire [3:0] stop_idx = nine ? 4'hA : 4'h9;
  wire [3:0] quiet_len = nine ? `ASR_QUIET_BITS_9 : `ASR_QUIET_BITS_8;
  wire fall = last_smp_r & ~smp;
  wire [7:0] rx_byte = nine ? shf_r[7:0] : shf_r[8:1];
  wire rx_msb = shf_r[8];
  wire wr_c1 = i_wr && (i_addr == `ASR_OFS_CTRL_ONE);
  wire wr_c2 = i_wr && (i_addr == `ASR_OFS_CTRL_TWO);
  wire rd_buf = i_rd && (i_addr == `ASR_OFS_DATA_BUF);
  wire addr_wake = done_r && standby_r && wake_addr && rx_msb;
  wire take = done_r && (!standby_r || addr_wake);
  wire idle_wake = quiet_hit_r && standby_r && !wake_addr;

  asr_tick_gen #(
    .DIV_W(8)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(rx_en),
    .i_div(baud_div_r),
    .o_tick(tick)  // see [R5]
  );

  // Bit recovery
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= ST_HUNT;
      rt_r <= 4'h0;
      bit_r <= 4'h0;
      hist_r <= 3'h0;
      smp_r <= 5'h00;
      last_smp_r <= 1'b1;
      prev_one_r <= 1'b0;
      shf_r <= 9'h000;
      nacc_r <= 1'b0;
      fe_r <= 1'b0;
      done_r <= 1'b0;
      quiet_bits_r <= 4'h0;
      quiet_sub_r <= 4'h0;
      quiet_arm_r <= 1'b0;
      quiet_hit_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      quiet_hit_r <= 1'b0;
      if (!rx_en) begin
        st_r <= ST_HUNT;
        hist_r <= 3'h0;
        quiet_bits_r <= 4'h0;
        quiet_sub_r <= 4'h0;
      end else if (tick) begin
        last_smp_r <= smp;
        smp_r <= {smp_r[3:0], smp};
        if (quiet_arm_r && quiet_bits_r >= quiet_len) begin
          quiet_hit_r <= 1'b1;  // see [R19]
          quiet_arm_r <= 1'b0;
        end
        case (st_r)
          ST_HUNT: begin
            hist_r <= {hist_r[1:0], smp};
            if (smp) begin
              quiet_sub_r <= quiet_sub_r + 4'h1;
              if (quiet_sub_r == 4'hF && quiet_bits_r != 4'hF) begin
                quiet_bits_r <= quiet_bits_r + 4'h1;
              end
            end else begin
              quiet_sub_r <= 4'h0;
              quiet_bits_r <= 4'h0;
            end
            if (!smp && hist_r == 3'b111) begin
              st_r <= ST_RECV;  // see [R7]
              rt_r <= 4'h1;  // see [R6]
              bit_r <= 4'h0;
              nacc_r <= 1'b0;
              prev_one_r <= 1'b0;
              quiet_bits_r <= 4'h0;  // see [R20]
            end
          end
          ST_RECV: begin
            rt_r <= rt_r + 4'h1;
            if (rt_r == `ASR_RT16) begin
              bit_r <= bit_r + 4'h1;
            end
            if (bit_r == 4'h0) begin
              if (rt_r == `ASR_RT7) begin
                // Two or more highs among ticks 3, 5 and 7
                if ((smp_r[3] & smp_r[1]) | (smp_r[3] & smp) | (smp_r[1] & smp)) begin
                  st_r <= ST_HUNT;  // see [R8]
                  rt_r <= 4'h0;  // see [R9]
                  hist_r <= 3'h0;
                end else if (smp_r[3] | smp_r[1] | smp) begin
                  nacc_r <= 1'b1;  // see [R8]
                end
              end
              if (rt_r == `ASR_RT10 && win != 3'b000) begin
                nacc_r <= 1'b1;  // see [R11]
              end
            end else if (rt_r == `ASR_RT10) begin
              if (split) begin
                nacc_r <= 1'b1;  // see [R10] [R12] [R24]
              end
              if (origin_stop) begin
                quiet_bits_r <= 4'h0;  // see [R20]
              end else if (vote) begin
                quiet_bits_r <= quiet_bits_r + 4'h1;
              end else begin
                quiet_bits_r <= 4'h0;
              end
              if (bit_r == stop_idx) begin
                fe_r <= ~vote;  // see [R12] [R13]
                done_r <= 1'b1;  // see [R3]
                quiet_arm_r <= 1'b1;
                quiet_sub_r <= 4'h0;
                hist_r <= {vote, vote, vote};
                st_r <= ST_HUNT;
              end else begin
                shf_r <= {vote, shf_r[8:1]};  // see [R23] [R1]
                prev_one_r <= vote;
              end
            end else if (fall && prev_one_r && bit_r != 4'h0) begin
              // Realign the count to a one-to-zero edge
              prev_one_r <= 1'b0;  // see [R6] [R14]
              rt_r <= 4'h1;
              if (rt_r > `ASR_RT10) begin
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          default: begin
            st_r <= ST_HUNT;
          end
        endcase
      end
    end
  end

  // Control registers and flags
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_one_r <= `ASR_RST_CTRL_ONE;  // see [R22]
      baud_div_r <= `ASR_RST_BAUD_DIV;
      full_irq_en_r <= 1'b0;
      quiet_irq_en_r <= 1'b0;
      standby_r <= 1'b0;
      ninth_r <= 1'b0;
      data_buf_r <= 8'h00;
      full_r <= 1'b0;
      quiet_r <= 1'b0;
      overrun_r <= 1'b0;
      noise_r <= 1'b0;
      framing_r <= 1'b0;
    end else begin
      if (wr_c1) begin
        ctrl_one_r <= i_wr_data;
      end
      if (i_wr && i_addr == `ASR_OFS_BAUD_DIV) begin
        baud_div_r <= i_wr_data;
      end
      if (wr_c2) begin
        full_irq_en_r <= i_wr_data[`ASR_C2_FULL_IRQ_EN];
        quiet_irq_en_r <= i_wr_data[`ASR_C2_QUIET_IRQ_EN];
      end
      if (addr_wake || idle_wake) begin
        standby_r <= 1'b0;  // see [R16] [R17]
      end else if (wr_c2) begin
        standby_r <= i_wr_data[`ASR_C2_STANDBY];  // see [R15] [R18]
      end
      // Reading the buffer clears flags; a new event in that cycle wins
      if (rd_buf) begin
        full_r <= 1'b0;
        quiet_r <= 1'b0;
        overrun_r <= 1'b0;
        noise_r <= 1'b0;
        framing_r <= 1'b0;
      end
      if (take) begin
        if (full_r && !rd_buf) begin
          overrun_r <= 1'b1;  // see [R21]
        end else begin
          data_buf_r <= rx_byte;  // see [R3]
          ninth_r <= rx_msb;  // see [R2]
          full_r <= 1'b1;  // see [R3] [R16]
          noise_r <= nacc_r;  // see [R24]
          framing_r <= fe_r;  // see [R13]
        end
      end
      if (quiet_hit_r && !idle_wake) begin
        quiet_r <= 1'b1;  // see [R17] [R19]
      end
    end
  end

  // Register read, data one cycle after the strobe
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ASR_OFS_CTRL_ONE: o_rd_data <= ctrl_one_r;
        `ASR_OFS_CTRL_TWO: o_rd_data <= {2'b00, full_irq_en_r, quiet_irq_en_r,
                                         2'b00, standby_r, ninth_r};
        `ASR_OFS_STATUS_ONE: o_rd_data <= {2'b00, full_r, quiet_r, overrun_r,
                                           noise_r, framing_r, 1'b0};
        `ASR_OFS_DATA_BUF: o_rd_data <= data_buf_r;
        `ASR_OFS_BAUD_DIV: o_rd_data <= baud_div_r;
        default: o_rd_data <= 8'h00;
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // Interrupt request, silenced in standby
  assign o_rx_irq = ~standby_r & ((full_r & full_irq_en_r) |
                                  (quiet_r & quiet_irq_en_r));  // see [R4] [R15] [R19]
endmodule

/* rtl/asr_defs.vh */
// Constants for the asynchronous serial receiver
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH
// Register offsets
`define ASR_OFS_CTRL_ONE 3'h0
`define ASR_OFS_CTRL_TWO 3'h1
`define ASR_OFS_STATUS_ONE 3'h2
`define ASR_OFS_DATA_BUF 3'h3
`define ASR_OFS_BAUD_DIV 3'h4
// Control register one fields
`define ASR_C1_RX_EN 6
`define ASR_C1_CHAR_LEN 4
`define ASR_C1_WAKE_SEL 3
`define ASR_C1_QUIET_ORIGIN 2
// Control register two fields
`define ASR_C2_FULL_IRQ_EN 5
`define ASR_C2_QUIET_IRQ_EN 4
`define ASR_C2_STANDBY 1
`define ASR_C2_NINTH_BIT 0
// Status register one fields
`define ASR_S1_FULL 5
`define ASR_S1_QUIET 4
`define ASR_S1_OVERRUN 3
`define ASR_S1_NOISE 2
`define ASR_S1_FRAMING 1
// Reset values
`define ASR_RST_CTRL_ONE 8'h00
`define ASR_RST_CTRL_TWO 8'h00
`define ASR_RST_BAUD_DIV 8'h00
// Oversample tick positions, stored as tick number minus one
`define ASR_RT3 4'h2
`define ASR_RT5 4'h4
`define ASR_RT7 4'h6
`define ASR_RT8 4'h7
`define ASR_RT9 4'h8
`define ASR_RT10 4'h9
`define ASR_RT16 4'hF
// Quiet line length in bit times for 8-bit and 9-bit characters
`define ASR_QUIET_BITS_8 4'hA
`define ASR_QUIET_BITS_9 4'hB
`endif

/* rtl/asr_tick_gen.v */
// Oversample tick generator, sixteen ticks per bit time
module asr_tick_gen #(
  parameter DIV_W = 8
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_run,
  input wire [DIV_W-1:0] i_div,
  output reg o_tick
);
  reg [DIV_W-1:0] cnt_r;
  wire [DIV_W-1:0] cnt_nxt;

  assign cnt_nxt = (cnt_r >= i_div) ? {DIV_W{1'b0}} : cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};

  // Tick every i_div plus one clocks
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= {DIV_W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_r <= {DIV_W{1'b0}};
      o_tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_tick <= (cnt_r >= i_div);
    end
  end
endmodule

/* dv/asr_rx_asserts.sv */
// Port assertions for the asynchronous serial receiver
module asr_rx_asserts (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_serial_in_pin,
  input wire [2:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rd_data,
  input wire o_rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] hi_cnt_r;
  wire quiet = hi_cnt_r >= 10'h384;
  // Long high line, no frame can still be completing
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) hi_cnt_r <= 10'h000;
    else if (!i_serial_in_pin) hi_cnt_r <= 10'h000;
    else if (hi_cnt_r != 10'h3FF) hi_cnt_r <= hi_cnt_r + 10'h001;
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_buf_rd;
    i_rd && i_addr == 3'h3 && quiet;
  endsequence
  sequence s_stat_rd;
    i_rd && i_addr == 3'h2;
  endsequence
  a_rdata_idle_zero: assert property (!i_rd |=> o_rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (i_rd && i_addr > 3'h4 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_irq_enable_off: assert property (
    i_wr && i_addr == 3'h1 && i_wr_data[5:4] == 2'b00 |=> !o_rx_irq)
    else $error("irq with both enables off");
  a_irq_standby: assert property (
    i_wr && i_addr == 3'h1 && i_wr_data[1] && quiet |=> !o_rx_irq [*2])
    else $error("irq during standby");
  a_flags_cleared: assert property (
    s_buf_rd ##2 s_stat_rd |=> (o_rd_data & 8'h3E) == 8'h00)
    else $error("flags not cleared by buffer read");
  a_irq_drop: assert property (s_buf_rd |=> !o_rx_irq)
    else $error("irq stays after flags cleared");
  a_ctrl_readback: assert property (
    i_wr && i_addr == 3'h0 ##1 i_rd && i_addr == 3'h0
    |=> (o_rd_data & 8'h5C) == ($past(i_wr_data, 2) & 8'h5C))
    else $error("control one readback wrong");
  a_enable_readback: assert property (
    i_wr && i_addr == 3'h1 ##1 i_rd && i_addr == 3'h1
    |=> (o_rd_data & 8'h30) == ($past(i_wr_data, 2) & 8'h30))
    else $error("irq enable readback wrong");
endmodule
bind asr_rx asr_rx_asserts u_asr_rx_asserts (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_serial_in_pin(i_serial_in_pin), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
  .i_rd(i_rd), .o_rd_data(o_rd_data), .o_rx_irq(o_rx_irq));

/* dv/asr_tx_model.sv */
// Behavioural far-end transmitter on the serial line
module asr_tx_model (
  input wire i_core_clk,
  input wire i_go,
  input wire [11:0] i_frame,
  input wire [3:0] i_nbits,
  input wire [5:0] i_bit_clks,
  input wire i_glitch,
  output logic o_line,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_line = 1'b1;
    o_busy = 1'b0;
  end
  // Frame bits go out index zero first, glitch hits one sample of bit one
  always begin
    @(posedge i_core_clk);
    if (i_go) begin
      o_busy <= 1'b1;
      for (int i = 0; i < i_nbits; i++) begin
        for (int j = 0; j < i_bit_clks; j++) begin
          o_line <= i_frame[i] ^ (i_glitch && i == 1 && j inside {16, 17});
          @(posedge i_core_clk);
        end
      end
      o_line <= 1'b1;
      o_busy <= 1'b0;
    end
  end
endmodule

/* dv/asr_rx_tb.sv */
// Testbench for the asynchronous serial receiver
module asr_rx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, gl = 0;
  logic [2:0] addr = 0;
  logic [7:0] wd = 0;
  logic [11:0] fr = 12'hFFF;
  logic [3:0] nb = 4'hA;
  logic [5:0] bc = 6'h20;
  logic [31:0] seed = 32'h7570A246, r;
  logic [8:0] d;
  wire line, busy, irq;
  wire [7:0] rdd;
  int err_total = 0, total_checks = 0, cyc = 0;
  asr_rx u_asr_rx (.i_core_clk(clk), .i_sys_rst(rst), .i_serial_in_pin(line), .i_addr(addr),
    .i_wr_data(wd), .i_wr(wr), .i_rd(rd), .o_rd_data(rdd), .o_rx_irq(irq));
  asr_tx_model u_asr_tx_model (.i_core_clk(clk), .i_go(go), .i_frame(fr), .i_nbits(nb),
    .i_bit_clks(bc), .i_glitch(gl), .o_line(line), .o_busy(busy));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] frame(input [8:0] v, input nine, input brk);
    return nine ? {1'b1, ~brk, v, 1'b0} : {2'b11, ~brk, v[7:0], 1'b0};
  endfunction
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input [7:0] s, input [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input [2:0] a, input [7:0] v);
    addr <= a;
    wd <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rchk(input string n, input [2:0] a, input [7:0] m, input [7:0] e);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    chk(n, rdd & m, e);
  endtask
  task automatic send(input [11:0] f, input nine, input [5:0] b, input g);
    repeat (8) @(posedge clk);
    fr <= f;
    nb <= nine ? 4'hB : 4'hA;
    bc <= b;
    gl <= g;
    go <= 1;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic expect_char(input [8:0] v, input nine, input [7:0] st);
    rchk("status", 3'h2, 8'h2E, st);
    rchk("ninth", 3'h1, 8'h01, {7'h0, nine ? v[8] : v[7]});
    rchk("data", 3'h3, 8'hFF, v[7:0]);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rchk("ctrl1 reset", 3'h0, 8'hFF, 8'h00);
    rchk("unmapped", 3'h5, 8'hFF, 8'h00);
    wreg(3'h2, 8'hFF);
    rchk("status ro", 3'h2, 8'h3E, 8'h00);
    wreg(3'h4, 8'h01);
    rchk("divisor", 3'h4, 8'hFF, 8'h01);
    wreg(3'h1, 8'h20);
    rchk("ctrl2", 3'h1, 8'h30, 8'h20);
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      d = k < 2 ? {9{k[0]}} : r[8:0];
      wreg(3'h0, {3'h2, r[9], 4'h0});
      send(frame(d, r[9], 0), r[9], 6'h1F + r[10] + r[11], 0);
      chk("irq", {7'h0, irq}, 8'h01);
      expect_char(d, r[9], 8'h20);
    end
    wreg(3'h0, 8'h40);
    send(frame(9'h000, 0, 1), 0, 6'h20, 0);
    expect_char(9'h000, 0, 8'h22);
    send(frame(9'h0A5, 0, 0), 0, 6'h20, 1);
    expect_char(9'h0A5, 0, 8'h24);
    send(frame(9'h03C, 0, 0), 0, 6'h20, 0);
    send(frame(9'h0C3, 0, 0), 0, 6'h20, 0);
    expect_char(9'h03C, 0, 8'h28);
    send(12'hFFE, 0, 6'h04, 0);
    rchk("false start", 3'h2, 8'h20, 8'h00);
    wreg(3'h1, 8'h10);
    send(frame(9'h05A, 0, 0), 0, 6'h20, 0);
    rchk("data", 3'h3, 8'hFF, 8'h5A);
    repeat (500) @(posedge clk);
    chk("idle irq", {7'h0, irq}, 8'h01);
    rchk("idle", 3'h2, 8'h10, 8'h10);
    wreg(3'h0, 8'h48);
    wreg(3'h1, 8'h32);
    send(frame(9'h005, 0, 0), 0, 6'h20, 0);
    chk("standby irq", {7'h0, irq}, 8'h00);
    rchk("ignored", 3'h2, 8'h20, 8'h00);
    send(frame(9'h085, 0, 0), 0, 6'h20, 0);
    rchk("woken", 3'h1, 8'h02, 8'h00);
    chk("wake irq", {7'h0, irq}, 8'h01);
    expect_char(9'h085, 0, 8'h20);
    wreg(3'h0, 8'h40);
    wreg(3'h1, 8'h12);
    repeat (500) @(posedge clk);
    rchk("idle wake", 3'h1, 8'h02, 8'h00);
    rchk("no idle", 3'h2, 8'h10, 8'h00);
    repeat (1000) @(posedge clk);
    wreg(3'h1, 8'h02);
    rchk("data kept", 3'h3, 8'hFF, 8'h85);
    rchk("flags", 3'h2, 8'h3E, 8'h00);
    wreg(3'h0, 8'h5C);
    rchk("ctrl1", 3'h0, 8'hFF, 8'h5C);
    complete_run();
  end
endmodule
